/* File: src/uhpm_pkg.sv */
// Package: shared constants for the bridge power-management sequencer and its controller
package uhpm_pkg;
    // ----------------------------------------------------------------
    // Command codes carried over the command strobe
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SLEEP = 8'h01;
    localparam logic [7:0] CMD_RUN = 8'h10;
    localparam logic [7:0] CMD_PERIPH_PM = 8'h12;
    localparam logic [7:0] CMD_PERIPH_RESET = 8'h13;
    localparam logic [7:0] CMD_GET_DESC = 8'h24;
    // Settings of the peripheral power command
    localparam logic [7:0] PM_RESUME = 8'h00;
    localparam logic [7:0] PM_SUSP_NO_RWU = 8'h01;
    localparam logic [7:0] PM_SUSP_RWU = 8'h02;
    // Event information bits
    localparam int EVT_ATTACH_CHANGE_BIT = 1;
    localparam int EVT_RWU_BIT = 0;
    // ----------------------------------------------------------------
    // Controller APB registers
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_WAKE = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_EVENT = 8'h0c;
    localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
    // Command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_ARG_LSB = 8;
    // Status register fields
    localparam int ST_READY_BIT = 0;
    localparam int ST_EVT_N_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_WAKE_BIT = 3;
    // Wake pulse phase length in core cycles
    localparam logic [7:0] WAKE_PHASE_CYC = 8'h04;
endpackage

/* File: src/uhpm_link_if.sv */
// Interface: pins and command link between the controller and the bridge
`timescale 1ns/100ps
interface uhpm_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [7:0] cmd_arg;
    logic wake_pin;
    logic serial_ready_out;
    logic event_irq_n;
    logic evt_valid;
    logic [7:0] evt_info;
    modport bridge (input cmd_valid, input cmd_code, input cmd_arg, input wake_pin,
                    output serial_ready_out, output event_irq_n, output evt_valid, output evt_info);
    modport ctrl (output cmd_valid, output cmd_code, output cmd_arg, output wake_pin,
                  input serial_ready_out, input event_irq_n, input evt_valid, input evt_info);
endinterface

/* File: src/uhpm_bridge.sv */
// Bridge power-management sequencer: sleep/active and USB port suspend/resume
//
// Summary of operation
// - CPU sends no commands while bridge sleeps
// - Sleep command enters sleep, ready drops
// - CPU wakes bridge with low-high-low pulse
// - Wake pulse without peripheral restores ready
// - Sleep accepted whatever run setting is
// - Setting 01h suspends, remote wakeup prohibited
// - Setting 00h resumes port and peripheral
// - Setting 02h suspends; remote wakeup resumes
// - Awake remote wakeup raises event
// - Sleep with peripheral suspends port first
// - Wake with peripheral resumes port, raises ready
// - Sleep keeps remote wakeup prohibited if unsupported
// - Asleep remote wakeup drives event pin low
// - Attach change asleep toggles event, reports flag
// - Unchanged attach state reports no event
// - CPU gets descriptor, resets on error
// - Detach-reattach unseen in remote-wakeup sleep
// - CPU probes descriptor after remote-wakeup sleep
// - Detach during sleep reported by bit 1
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module uhpm_bridge (
    input wire logic core_clk_i,
    input wire logic rst_i,
    uhpm_link_if.bridge link,
    input wire logic attached_i,
    input wire logic rwu_capable_i,
    input wire logic remote_wake_i,
    output logic port_suspend_o,
    output logic resume_o,
    output logic rwu_enable_o,
    output logic run_o
);
    // ----------------------------------------------------------------
    // Synchronisers for pins from outside
    // ----------------------------------------------------------------
    logic [2:0] wake_sync_ff;
    logic [1:0] att_sync_ff;
    logic [1:0] rwk_sync_ff;
    logic [1:0] cap_sync_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_sync_ff <= 3'h0;
            att_sync_ff <= 2'h0;
            rwk_sync_ff <= 2'h0;
            cap_sync_ff <= 2'h0;
        end else begin
            wake_sync_ff <= {wake_sync_ff[1:0], link.wake_pin};
            att_sync_ff <= {att_sync_ff[0], attached_i};
            rwk_sync_ff <= {rwk_sync_ff[0], remote_wake_i};
            cap_sync_ff <= {cap_sync_ff[0], rwu_capable_i};
        end
    end
    logic wake_lvl;
    logic wake_prev;
    logic attached;
    logic rwk;
    assign wake_lvl = wake_sync_ff[1];
    assign wake_prev = wake_sync_ff[2];
    assign attached = att_sync_ff[1];
    assign rwk = rwk_sync_ff[1];

    // ----------------------------------------------------------------
    // Bridge state machine
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'h1,
        ST_SLEEP_HI = 3'h2,
        ST_SLEEP = 3'h4
    } uhpm_state_t;
    uhpm_state_t state_ff;
    logic asleep;
    assign asleep = (state_ff != ST_ACTIVE);
    logic cmd_ok;
    assign cmd_ok = link.cmd_valid && !asleep;
    logic sleep_cmd;
    assign sleep_cmd = cmd_ok && link.cmd_code == uhpm_pkg::CMD_SLEEP;
    logic pm_cmd;
    assign pm_cmd = cmd_ok && link.cmd_code == uhpm_pkg::CMD_PERIPH_PM;
    // Pulse complete when synced pin falls after a high phase seen in sleep
    logic wake_done;
    assign wake_done = (state_ff == ST_SLEEP_HI) && wake_prev && !wake_lvl;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_ACTIVE;
        end else begin
            case (state_ff)
                ST_ACTIVE: begin
                    if (sleep_cmd) begin
                        state_ff <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    // Only a rise seen while asleep starts a pulse; pin is ignored while active
                    if (wake_lvl && !wake_prev) begin
                        state_ff <= ST_SLEEP_HI;
                    end
                end
                ST_SLEEP_HI: begin
                    if (wake_done) begin
                        state_ff <= ST_ACTIVE;
                    end
                end
                default: begin
                    state_ff <= ST_ACTIVE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Run setting, held only for the user side
    // ----------------------------------------------------------------
    logic run_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_ff <= 1'b0;
        end else if (cmd_ok && link.cmd_code == uhpm_pkg::CMD_RUN) begin
            run_ff <= link.cmd_arg[0];
        end
    end
    assign run_o = run_ff;

    // ----------------------------------------------------------------
    // USB port suspend / remote wakeup
    // ----------------------------------------------------------------
    logic susp_ff;
    logic rwu_ff;
    logic resume_ff;
    logic rwu_resume;
    assign rwu_resume = susp_ff && rwu_ff && rwk;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            susp_ff <= 1'b0;
            rwu_ff <= 1'b0;
            resume_ff <= 1'b0;
        end else begin
            resume_ff <= 1'b0;
            if (sleep_cmd && attached) begin
                susp_ff <= 1'b1;
                rwu_ff <= cap_sync_ff[1];
            end else if (pm_cmd && link.cmd_arg == uhpm_pkg::PM_SUSP_NO_RWU && attached) begin
                susp_ff <= 1'b1;
                rwu_ff <= 1'b0;
            end else if (pm_cmd && link.cmd_arg == uhpm_pkg::PM_SUSP_RWU && attached) begin
                susp_ff <= 1'b1;
                rwu_ff <= 1'b1;
            end else if (susp_ff && (wake_done || (pm_cmd && link.cmd_arg == uhpm_pkg::PM_RESUME))) begin
                susp_ff <= 1'b0;
                resume_ff <= 1'b1;
            end else if (rwu_resume && !asleep) begin
                susp_ff <= 1'b0;
                resume_ff <= 1'b1;
            end
        end
    end
    assign port_suspend_o = susp_ff;
    assign resume_o = resume_ff;
    assign rwu_enable_o = rwu_ff;

    // ----------------------------------------------------------------
    // Attach tracking and event reporting
    // ----------------------------------------------------------------
    logic att_before_ff;
    logic irq_n_ff;
    logic rwk_seen_ff;
    logic evt_valid_ff;
    logic [7:0] evt_info_ff;
    // Remote-wakeup sleep leaves the port suspended; a detach/reattach is not tracked there
    logic att_watch;
    assign att_watch = !(susp_ff && rwu_ff);
    logic att_changed;
    assign att_changed = att_watch && (attached != att_before_ff);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            att_before_ff <= 1'b0;
            irq_n_ff <= 1'b1;
            rwk_seen_ff <= 1'b0;
            evt_valid_ff <= 1'b0;
            evt_info_ff <= 8'h00;
        end else begin
            evt_valid_ff <= 1'b0;
            if (!asleep) begin
                irq_n_ff <= 1'b1;
                if (att_changed) begin
                    // Reports both awake changes and changes found on waking
                    att_before_ff <= attached;
                    evt_valid_ff <= 1'b1;
                    evt_info_ff <= 8'h00;
                    evt_info_ff[uhpm_pkg::EVT_ATTACH_CHANGE_BIT] <= 1'b1;
                end else if (rwk_seen_ff || rwu_resume) begin
                    rwk_seen_ff <= 1'b0;
                    evt_valid_ff <= 1'b1;
                    evt_info_ff <= 8'h00;
                    evt_info_ff[uhpm_pkg::EVT_RWU_BIT] <= 1'b1;
                end
            end else begin
                if (rwu_resume && !rwk_seen_ff) begin
                    rwk_seen_ff <= 1'b1;
                    irq_n_ff <= 1'b0;
                end
                if (att_changed) begin
                    irq_n_ff <= 1'b0;
                end
                // Equal attach state at wake gives no event since att_changed stays low
            end
        end
    end
    assign link.serial_ready_out = !asleep;
    assign link.event_irq_n = irq_n_ff;
    assign link.evt_valid = evt_valid_ff;
    assign link.evt_info = evt_info_ff;
endmodule

/* File: src/uhpm_ctrl.sv */
// Controller end: APB registers drive commands and the wake pin toward the bridge
`timescale 1ns/100ps
module uhpm_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    uhpm_link_if.ctrl link
);
    // ----------------------------------------------------------------
    // Synchronised bridge pins
    // ----------------------------------------------------------------
    logic [1:0] rdy_sync_ff;
    logic [1:0] irq_sync_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdy_sync_ff <= 2'h0;
            irq_sync_ff <= 2'h3;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[0], link.serial_ready_out};
            irq_sync_ff <= {irq_sync_ff[0], link.event_irq_n};
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic wr;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    logic mapped;
    assign mapped = paddr == uhpm_pkg::REG_CMD || paddr == uhpm_pkg::REG_WAKE ||
                    paddr == uhpm_pkg::REG_STATUS || paddr == uhpm_pkg::REG_EVENT;
    assign pslverr = psel && penable && !mapped;

    // Command is dropped while the bridge sleeps; software must wake it first
    logic cmd_valid_ff;
    logic [7:0] cmd_code_ff;
    logic [7:0] cmd_arg_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_valid_ff <= 1'b0;
            cmd_code_ff <= 8'h00;
            cmd_arg_ff <= 8'h00;
        end else begin
            cmd_valid_ff <= 1'b0;
            if (wr && paddr == uhpm_pkg::REG_CMD && rdy_sync_ff[1]) begin
                cmd_valid_ff <= 1'b1;
                cmd_code_ff <= pwdata[uhpm_pkg::CMD_CODE_LSB +: 8];
                cmd_arg_ff <= pwdata[uhpm_pkg::CMD_ARG_LSB +: 8];
            end
        end
    end

    // ----------------------------------------------------------------
    // Wake pulse generator: low, high for a phase, back low
    // ----------------------------------------------------------------
    logic wake_ff;
    logic [7:0] wcnt_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_ff <= 1'b0;
            wcnt_ff <= 8'h00;
        end else if (wcnt_ff != 8'h00) begin
            wcnt_ff <= wcnt_ff - 8'h01;
            if (wcnt_ff == 8'h01) begin
                wake_ff <= 1'b0;
            end
        end else if (wr && paddr == uhpm_pkg::REG_WAKE && pwdata[0]) begin
            wake_ff <= 1'b1;
            wcnt_ff <= uhpm_pkg::WAKE_PHASE_CYC;
        end
    end

    // Latest event information, kept until read
    logic [7:0] evt_ff;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_ff <= 8'h00;
        end else if (link.evt_valid) begin
            evt_ff <= link.evt_info;
        end else if (psel && penable && !pwrite && paddr == uhpm_pkg::REG_EVENT) begin
            evt_ff <= 8'h00;
        end
    end

    always_comb begin
        prdata = uhpm_pkg::REG_RESET_VAL;
        if (psel && !pwrite) begin
            case (paddr)
                uhpm_pkg::REG_STATUS: begin
                    prdata[uhpm_pkg::ST_READY_BIT] = rdy_sync_ff[1];
                    prdata[uhpm_pkg::ST_EVT_N_BIT] = irq_sync_ff[1];
                    prdata[uhpm_pkg::ST_BUSY_BIT] = cmd_valid_ff;
                    prdata[uhpm_pkg::ST_WAKE_BIT] = wake_ff;
                end
                uhpm_pkg::REG_EVENT: prdata[7:0] = evt_ff;
                uhpm_pkg::REG_CMD: prdata[15:0] = {cmd_arg_ff, cmd_code_ff};
                default: prdata = uhpm_pkg::REG_RESET_VAL;
            endcase
        end
    end

    assign link.cmd_valid = cmd_valid_ff;
    assign link.cmd_code = cmd_code_ff;
    assign link.cmd_arg = cmd_arg_ff;
    assign link.wake_pin = wake_ff;
endmodule

/* File: sim/uhpm_props.sv */
// Checker: timing properties of the link between controller and bridge
`timescale 1ns/100ps
module uhpm_props (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic wake_pin,
    input wire logic serial_ready_out,
    input wire logic event_irq_n,
    input wire logic evt_valid,
    input wire logic [7:0] evt_info
);
    logic [7:0] since_hi_ff;
    logic [3:0] low_cnt_ff;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Age of the last wake-pin high level; saturates so a stale pulse never qualifies
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            since_hi_ff <= 8'hff;
        end else if (wake_pin) begin
            since_hi_ff <= 8'h00;
        end else if (since_hi_ff != 8'hff) begin
            since_hi_ff <= since_hi_ff + 8'h01;
        end
    end
    // Cycles spent asleep, long enough for the controller's ready sync to settle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_ff <= 4'h0;
        end else if (serial_ready_out) begin
            low_cnt_ff <= 4'h0;
        end else if (low_cnt_ff != 4'hf) begin
            low_cnt_ff <= low_cnt_ff + 4'h1;
        end
    end
    sequence s_wake_pulse;
        wake_pin [*4] ##1 !wake_pin;
    endsequence
    AST_SLEEP_READY_LOW: assert property (
        cmd_valid && cmd_code == uhpm_pkg::CMD_SLEEP && serial_ready_out |=> !serial_ready_out)
        else $error("sleep command left ready high");
    AST_WAKE_PULSE_SHAPE: assert property (
        $rose(wake_pin) |-> s_wake_pulse)
        else $error("wake pulse not four cycles high");
    AST_WAKE_RESTORES: assert property (
        $fell(wake_pin) && !serial_ready_out |-> ##[1:10] serial_ready_out)
        else $error("wake pulse did not restore ready");
    AST_READY_NEEDS_WAKE: assert property (
        $rose(serial_ready_out) |-> since_hi_ff <= 8'h0a)
        else $error("ready rose without a recent wake pulse");
    AST_NO_CMD_ASLEEP: assert property (
        low_cnt_ff >= 4'h5 |-> !cmd_valid)
        else $error("command sent to a sleeping bridge");
    AST_EVT_ONE_PULSE: assert property (
        evt_valid |=> !evt_valid)
        else $error("event strobe longer than one cycle");
    AST_EVT_HAS_CAUSE: assert property (
        evt_valid |-> evt_info[uhpm_pkg::EVT_ATTACH_CHANGE_BIT] || evt_info[uhpm_pkg::EVT_RWU_BIT])
        else $error("event strobe without a cause bit");
    AST_EVT_WHEN_ACTIVE: assert property (
        evt_valid |-> ##[0:1] serial_ready_out)
        else $error("event delivered while asleep");
    AST_IRQ_FALL_ASLEEP: assert property (
        $fell(event_irq_n) |-> !serial_ready_out)
        else $error("event pin fell while active");
    AST_IRQ_HOLDS: assert property (
        !event_irq_n && !serial_ready_out |=> !event_irq_n || serial_ready_out)
        else $error("event pin released before wake");
endmodule

/* File: sim/usb_host_bridge_power_mgmt_tb.sv */
// Testbench: controller and bridge joined over the link, driven through APB
`timescale 1ns/100ps
module usb_host_bridge_power_mgmt_tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic pready, pslverr, port_susp, resume, rwu_en, run;
    logic attached = 1'b0, rwu_cap = 1'b0, rwake = 1'b0;
    int fails = 0, n_checks = 0, n_resume = 0, cyc = 0, r;
    uhpm_link_if i_uhpm_link_if ();
    uhpm_ctrl i_uhpm_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(i_uhpm_link_if.ctrl));
    uhpm_bridge i_uhpm_bridge (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(i_uhpm_link_if.bridge),
        .attached_i(attached), .rwu_capable_i(rwu_cap), .remote_wake_i(rwake), .port_suspend_o(port_susp),
        .resume_o(resume), .rwu_enable_o(rwu_en), .run_o(run));
    uhpm_props i_uhpm_props (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid(i_uhpm_link_if.cmd_valid),
        .cmd_code(i_uhpm_link_if.cmd_code), .wake_pin(i_uhpm_link_if.wake_pin),
        .serial_ready_out(i_uhpm_link_if.serial_ready_out), .event_irq_n(i_uhpm_link_if.event_irq_n),
        .evt_valid(i_uhpm_link_if.evt_valid), .evt_info(i_uhpm_link_if.evt_info));
    always #5 core_clk_i = ~core_clk_i;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Resume pulses are counted here so no single-cycle strobe is missed
    always @(posedge core_clk_i) begin
        cyc++;
        if (resume === 1'b1) n_resume++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // Leading edge keeps an idle cycle between transfers, so psel is never written twice per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_sig(input logic irq, input logic exp);
        int n;
        n = 0;
        while ((irq ? i_uhpm_link_if.event_irq_n : i_uhpm_link_if.serial_ready_out) !== exp && n < 40) begin
            @(posedge core_clk_i);
            n++;
        end
        chk({31'h0, irq ? i_uhpm_link_if.event_irq_n : i_uhpm_link_if.serial_ready_out}, {31'h0, exp});
    endtask
    task automatic sleep();
        apb(1'b1, uhpm_pkg::REG_CMD, {24'h0, uhpm_pkg::CMD_SLEEP});
        wait_sig(1'b0, 1'b0);
    endtask
    task automatic wake();
        apb(1'b1, uhpm_pkg::REG_WAKE, 32'h1);
        wait_sig(1'b0, 1'b1);
        cycles(4);
    endtask
    task automatic pm(input logic [7:0] s);
        apb(1'b1, uhpm_pkg::REG_CMD, {16'h0, s, uhpm_pkg::CMD_PERIPH_PM});
        cycles(4);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_nodev();
        apb(1'b0, uhpm_pkg::REG_CMD, 32'h0);
        chk(rd_data, uhpm_pkg::REG_RESET_VAL);
        apb(1'b0, uhpm_pkg::REG_STATUS, 32'h0);
        chk(rd_data, 32'h0000_0003);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        apb(1'b1, uhpm_pkg::REG_WAKE, 32'h1);
        apb(1'b0, uhpm_pkg::REG_STATUS, 32'h0);
        chk(rd_data, 32'h0000_000b);
        cycles(12);
        chk({31'h0, i_uhpm_link_if.serial_ready_out}, 32'h1);
        sleep();
        cycles(20);
        chk({31'h0, i_uhpm_link_if.serial_ready_out}, 32'h0);
        wake();
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, uhpm_pkg::REG_CMD, {23'h0, i[0], uhpm_pkg::CMD_RUN});
            cycles(3);
            chk({31'h0, run}, 32'(i));
            sleep();
            apb(1'b1, uhpm_pkg::REG_CMD, {23'h0, ~i[0], uhpm_pkg::CMD_RUN});
            cycles(3);
            chk({31'h0, run}, 32'(i));
            wake();
            apb(1'b0, uhpm_pkg::REG_EVENT, 32'h0);
            chk(rd_data, 32'h0);
        end
    endtask
    task automatic t_suspend();
        attached <= 1'b1;
        cycles(10);
        apb(1'b0, uhpm_pkg::REG_EVENT, 32'h0);
        r = n_resume;
        pm(uhpm_pkg::PM_SUSP_NO_RWU);
        chk({30'h0, port_susp, rwu_en}, 32'h2);
        pm(uhpm_pkg::PM_RESUME);
        chk({31'h0, port_susp}, 32'h0);
        chk(32'(n_resume - r), 32'h1);
        pm(uhpm_pkg::PM_SUSP_RWU);
        chk({30'h0, port_susp, rwu_en}, 32'h3);
        rwake <= 1'b1;
        cycles(4);
        rwake <= 1'b0;
        cycles(8);
        chk({31'h0, port_susp}, 32'h0);
        chk(32'(n_resume - r), 32'h2);
        apb(1'b0, uhpm_pkg::REG_EVENT, 32'h0);
        chk({31'h0, rd_data[uhpm_pkg::EVT_RWU_BIT]}, 32'h1);
    endtask
    task automatic t_sleep_dev();
        sleep();
        chk({30'h0, port_susp, rwu_en}, 32'h2);
        r = n_resume;
        wake();
        chk({31'h0, port_susp}, 32'h0);
        chk(32'(n_resume - r), 32'h1);
        apb(1'b0, uhpm_pkg::REG_EVENT, 32'h0);
        chk(rd_data, 32'h0);
        for (int j = 0; j < 2; j++) begin
            sleep();
            attached <= j[0];
            wait_sig(1'b1, 1'b0);
            wake();
            apb(1'b0, uhpm_pkg::REG_EVENT, 32'h0);
            chk({31'h0, rd_data[uhpm_pkg::EVT_ATTACH_CHANGE_BIT]}, 32'h1);
        end
        apb(1'b1, uhpm_pkg::REG_CMD, {24'h0, uhpm_pkg::CMD_GET_DESC});
        apb(1'b0, uhpm_pkg::REG_CMD, 32'h0);
        chk(rd_data, {24'h0, uhpm_pkg::CMD_GET_DESC});
        apb(1'b1, uhpm_pkg::REG_CMD, {24'h0, uhpm_pkg::CMD_PERIPH_RESET});
        apb(1'b0, uhpm_pkg::REG_CMD, 32'h0);
        chk(rd_data, {24'h0, uhpm_pkg::CMD_PERIPH_RESET});
    endtask
    task automatic t_sleep_rwu();
        rwu_cap <= 1'b1;
        sleep();
        chk({30'h0, port_susp, rwu_en}, 32'h3);
        attached <= 1'b0;
        cycles(6);
        attached <= 1'b1;
        cycles(8);
        chk({31'h0, i_uhpm_link_if.event_irq_n}, 32'h1);
        rwake <= 1'b1;
        cycles(4);
        rwake <= 1'b0;
        wait_sig(1'b1, 1'b0);
        r = n_resume;
        wake();
        chk(32'(n_resume - r), 32'h1);
        apb(1'b0, uhpm_pkg::REG_STATUS, 32'h0);
        chk({31'h0, rd_data[uhpm_pkg::ST_EVT_N_BIT]}, 32'h1);
        apb(1'b0, uhpm_pkg::REG_EVENT, 32'h0);
        chk(rd_data, 32'h0000_0001);
        apb(1'b1, uhpm_pkg::REG_CMD, {24'h0, uhpm_pkg::CMD_GET_DESC});
        apb(1'b0, uhpm_pkg::REG_CMD, 32'h0);
        chk(rd_data, {24'h0, uhpm_pkg::CMD_GET_DESC});
    endtask
    initial begin
        cycles(6);
        rst_i <= 1'b0;
        t_nodev();
        t_suspend();
        t_sleep_dev();
        t_sleep_rwu();
        complete_run();
    end
endmodule
